// File: cpu_irq_model.sv
`timescale 1ns/1ps

// CPU core and interrupt controller stand-in; tasks are entered at a falling edge
module cpu_irq_model (
    input  wire logic              clk_in,
    output logic                   wait_out,
    output logic [2:0]             cpu_pri_out,
    output pwr_mode_pkg::irq_req_t irq_out
);
    // Quiet core at time zero
    initial begin
        wait_out    = 1'b0;
        cpu_pri_out = 3'h3;
        irq_out     = '0;
    end

    // One-cycle wait pulse carrying the current priority
    task automatic exec_wait(input logic [2:0] pri);
        cpu_pri_out = pri;
        wait_out    = 1'b1;
        @(negedge clk_in);
        wait_out    = 1'b0;
    endtask

    // Pending enabled interrupt, held as a level until cleared
    task automatic set_irq(input logic ok, input logic [2:0] pri);
        irq_out = '{valid: 1'b1, sleep_ok: ok, pri: pri};
    endtask

    task automatic clr_irq();
        irq_out = '0;
    endtask
endmodule

// File: pwr_mode_pkg.sv
package pwr_mode_pkg;

    // System clock
    localparam int CLK_PERIOD_NS = 40;

    // Field positions inside the control words
    localparam int SLEEP_SELECT_BIT = 4;   // Within oscillator_control_reg
    localparam int REG_STBY_BIT     = 0;   // Within power_control_reg

    // Oscillator source codes
    localparam logic [2:0] OSC_FRC  = 3'h0;
    localparam logic [2:0] OSC_PLL  = 3'h1;
    localparam logic [2:0] OSC_PRI  = 3'h2;
    localparam logic [2:0] OSC_SOSC = 3'h4;
    localparam logic [2:0] OSC_LOW_POWER_RC_OSC = 3'h5;

    // Wake-up times per source, and regulator recovery time
    localparam int WAKE_FRC_NS  = 200;
    localparam int WAKE_PLL_NS  = 2000;
    localparam int WAKE_PRI_NS  = 1000;
    localparam int WAKE_SOSC_NS = 4000;
    localparam int WAKE_LOW_POWER_RC_OSC_NS = 400;
    localparam int STBY_EXTRA_NS = 10000;

    // Derived cycle counts, rounded up
    localparam logic [11:0] WAKE_FRC_CYC  = 12'((WAKE_FRC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] WAKE_PLL_CYC  = 12'((WAKE_PLL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] WAKE_PRI_CYC  = 12'((WAKE_PRI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] WAKE_SOSC_CYC = 12'((WAKE_SOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] WAKE_LOW_POWER_RC_OSC_CYC = 12'((WAKE_LOW_POWER_RC_OSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] STBY_EXTRA_CYC = 12'((STBY_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Unlock keys, values arbitrary
    localparam logic [31:0] UNLOCK_KEY1 = 32'h5A5A_C3C3;
    localparam logic [31:0] UNLOCK_KEY2 = 32'hA5A5_3C3C;

    // Power modes
    typedef enum logic [3:0] {
        ST_RUN   = 4'h1,
        ST_IDLE  = 4'h2,
        ST_SLEEP = 4'h4,
        ST_WAKE  = 4'h8
    } mode_t;

    // Interrupt request from the interrupt controller
    typedef struct packed {
        logic       valid;      // Enabled source is requesting
        logic       sleep_ok;   // Source operates in Sleep
        logic [2:0] pri;
    } irq_req_t;

    // Clock gating toward CPU and peripherals
    typedef struct packed {
        logic cpu_clk_en;
        logic periph_bus_clk_en;
        logic cpu_halt;
    } clk_ctrl_t;

    // Functions kept alive in Sleep
    typedef struct packed {
        logic pin_change;
        logic watchdog;
        logic adc;
        logic uart;
        logic ext_lowpower_clk;
    } keep_alive_t;

    // Wake-up delay for an oscillator source
    function automatic logic [11:0] osc_delay(input logic [2:0] src);
        case (src)
            OSC_PLL:  osc_delay = WAKE_PLL_CYC;
            OSC_PRI:  osc_delay = WAKE_PRI_CYC;
            OSC_SOSC: osc_delay = WAKE_SOSC_CYC;
            OSC_LOW_POWER_RC_OSC: osc_delay = WAKE_LOW_POWER_RC_OSC_CYC;
            default:  osc_delay = WAKE_FRC_CYC;
        endcase
    endfunction

endpackage

// File: sleep_standby_mode_control.sv
`timescale 1ns/1ps

module sleep_standby_mode_control #(
    parameter int NUM_PERIPH = 8
) (
    input  wire logic                   REF_CLK_IN,
    input  wire logic                   RST_N_IN,
    input  wire logic                   WAIT_IN,
    input  wire logic [2:0]             CPU_PRI_IN,
    input  wire pwr_mode_pkg::irq_req_t IRQ_IN,
    input  wire logic                   WATCHDOG_TIMEOUT_IN,
    input  wire logic                   BROWNOUT_IN,
    input  wire logic                   RESET_REQ_IN,
    input  wire logic [2:0]             OSC_SRC_IN,
    input  wire logic                   UNLOCK_WR_IN,
    input  wire logic [31:0]            UNLOCK_DATA_IN,
    input  wire logic                   OSC_CTRL_WR_IN,
    input  wire logic [31:0]            OSC_CTRL_DATA_IN,
    input  wire logic                   PWR_CTRL_WR_IN,
    input  wire logic [31:0]            PWR_CTRL_DATA_IN,
    input  wire logic [NUM_PERIPH-1:0]  STOP_IN_IDLE_IN,
    output pwr_mode_pkg::clk_ctrl_t     CLK_CTRL_OUT,
    output pwr_mode_pkg::keep_alive_t   KEEP_ALIVE_OUT,
    output logic                        SLEEP_OUT,
    output logic                        IDLE_OUT,
    output logic                        REG_STANDBY_OUT,
    output logic                        CLK_FAIL_MON_EN_OUT,
    output logic                        BROWNOUT_EN_OUT,
    output logic                        PIN_DRIVE_HOLD_OUT,
    output logic [NUM_PERIPH-1:0]       PERIPH_HALT_OUT,
    output logic                        DEVICE_RESET_OUT,
    output logic                        SLEEP_SELECT_OUT,
    output logic                        REG_STBY_SEL_OUT
);

    pwr_mode_pkg::mode_t mode_q;
    pwr_mode_pkg::mode_t mode_d;
    logic [11:0]         wake_cnt_q;
    logic [11:0]         wake_cnt_d;
    logic                stby_q;
    logic                stby_d;
    logic                sleep_sel_q;
    logic                sleep_sel_d;
    logic                reg_stby_sel_q;
    logic                reg_stby_sel_d;
    logic                unlocked;
    logic                dev_reset;
    logic                irq_hi;
    logic                irq_lo;

    // Any device reset source, brownout included
    assign dev_reset = BROWNOUT_IN || RESET_REQ_IN;

    // Priority comparison of the pending interrupt
    assign irq_hi = IRQ_IN.valid && (IRQ_IN.pri > CPU_PRI_IN);
    assign irq_lo = IRQ_IN.valid && (IRQ_IN.pri <= CPU_PRI_IN);

    // Guard for protected writes
    unlock_seq u_unlock (
        .clk_in       (REF_CLK_IN),
        .rst_n_in     (RST_N_IN),
        .key_wr_in    (UNLOCK_WR_IN),
        .key_data_in  (UNLOCK_DATA_IN),
        .clear_in     (dev_reset),
        .unlocked_out (unlocked)
    );

    // Control bits written by software
    always_comb begin
        sleep_sel_d    = sleep_sel_q;
        reg_stby_sel_d = reg_stby_sel_q;
        if (dev_reset) begin
            sleep_sel_d    = 1'b0;
            reg_stby_sel_d = 1'b0;
        end else begin
            if (OSC_CTRL_WR_IN && unlocked) begin
                sleep_sel_d = OSC_CTRL_DATA_IN[pwr_mode_pkg::SLEEP_SELECT_BIT];
            end
            if (PWR_CTRL_WR_IN) begin
                reg_stby_sel_d = PWR_CTRL_DATA_IN[pwr_mode_pkg::REG_STBY_BIT];
            end
        end
    end

    // Mode sequencer
    always_comb begin
        mode_d     = mode_q;
        wake_cnt_d = wake_cnt_q;
        stby_d     = stby_q;
        if (dev_reset) begin
            mode_d     = pwr_mode_pkg::ST_RUN;
            wake_cnt_d = 12'h000;
            stby_d     = 1'b0;
        end else begin
            unique case (mode_q)
                pwr_mode_pkg::ST_RUN: begin
                    if (WAIT_IN && sleep_sel_q) begin
                        mode_d = pwr_mode_pkg::ST_SLEEP;
                        stby_d = reg_stby_sel_q;
                    end else if (WAIT_IN) begin
                        mode_d = pwr_mode_pkg::ST_IDLE;
                    end
                end
                pwr_mode_pkg::ST_IDLE: begin
                    if (irq_hi || WATCHDOG_TIMEOUT_IN) begin
                        mode_d = pwr_mode_pkg::ST_RUN;
                    end
                end
                pwr_mode_pkg::ST_SLEEP: begin
                    if ((irq_hi && IRQ_IN.sleep_ok) || WATCHDOG_TIMEOUT_IN) begin
                        mode_d     = pwr_mode_pkg::ST_WAKE;
                        wake_cnt_d = 12'(pwr_mode_pkg::osc_delay(OSC_SRC_IN)
                                     + (stby_q ? pwr_mode_pkg::STBY_EXTRA_CYC : 12'h000));
                    end else if (irq_lo && IRQ_IN.sleep_ok) begin
                        mode_d = pwr_mode_pkg::ST_IDLE;
                        stby_d = 1'b0;
                    end
                end
                pwr_mode_pkg::ST_WAKE: begin
                    wake_cnt_d = wake_cnt_q - 12'h001;
                    if (wake_cnt_q <= 12'h001) begin
                        mode_d     = pwr_mode_pkg::ST_RUN;
                        wake_cnt_d = 12'h000;
                        stby_d     = 1'b0;
                    end
                end
            endcase
        end
    end

    // Outputs computed from the next mode
    pwr_mode_pkg::clk_ctrl_t   clk_d;
    pwr_mode_pkg::keep_alive_t keep_d;
    logic                      sleep_d;
    logic                      idle_d;
    logic                      reg_stby_d;
    logic                      cfm_d;
    logic [NUM_PERIPH-1:0]     halt_d;

    always_comb begin
        clk_d      = '{cpu_clk_en: 1'b1, periph_bus_clk_en: 1'b1, cpu_halt: 1'b0};
        keep_d     = '{default: 1'b1};
        sleep_d    = 1'b0;
        idle_d     = 1'b0;
        reg_stby_d = 1'b0;
        cfm_d      = 1'b1;
        halt_d     = '0;
        unique case (mode_d)
            pwr_mode_pkg::ST_RUN: begin
            end
            pwr_mode_pkg::ST_IDLE: begin
                clk_d.cpu_halt = 1'b1;
                halt_d         = STOP_IN_IDLE_IN;
            end
            pwr_mode_pkg::ST_SLEEP: begin
                clk_d      = '{cpu_clk_en: 1'b0, periph_bus_clk_en: 1'b0, cpu_halt: 1'b1};
                halt_d     = '1;
                sleep_d    = 1'b1;
                cfm_d      = 1'b0;
                reg_stby_d = stby_d;
            end
            pwr_mode_pkg::ST_WAKE: begin
                clk_d  = '{cpu_clk_en: 1'b0, periph_bus_clk_en: 1'b0, cpu_halt: 1'b1};
                halt_d = '1;
                cfm_d  = 1'b0;
            end
        endcase
        idle_d = (mode_d == pwr_mode_pkg::ST_IDLE);
    end

    // State registers
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mode_q         <= pwr_mode_pkg::ST_RUN;
            wake_cnt_q     <= 12'h000;
            stby_q         <= 1'b0;
            sleep_sel_q    <= 1'b0;
            reg_stby_sel_q <= 1'b0;
        end else begin
            mode_q         <= mode_d;
            wake_cnt_q     <= wake_cnt_d;
            stby_q         <= stby_d;
            sleep_sel_q    <= sleep_sel_d;
            reg_stby_sel_q <= reg_stby_sel_d;
        end
    end

    // Output registers
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            CLK_CTRL_OUT        <= '{cpu_clk_en: 1'b1, periph_bus_clk_en: 1'b1, cpu_halt: 1'b0};
            KEEP_ALIVE_OUT      <= '{default: 1'b1};
            SLEEP_OUT           <= 1'b0;
            IDLE_OUT            <= 1'b0;
            REG_STANDBY_OUT     <= 1'b0;
            CLK_FAIL_MON_EN_OUT <= 1'b1;
            BROWNOUT_EN_OUT     <= 1'b1;
            PIN_DRIVE_HOLD_OUT  <= 1'b1;
            PERIPH_HALT_OUT     <= '0;
            DEVICE_RESET_OUT    <= 1'b0;
            SLEEP_SELECT_OUT    <= 1'b0;
            REG_STBY_SEL_OUT    <= 1'b0;
        end else begin
            CLK_CTRL_OUT        <= clk_d;
            KEEP_ALIVE_OUT      <= keep_d;
            SLEEP_OUT           <= sleep_d;
            IDLE_OUT            <= idle_d;
            REG_STANDBY_OUT     <= reg_stby_d;
            CLK_FAIL_MON_EN_OUT <= cfm_d;
            BROWNOUT_EN_OUT     <= 1'b1;
            PIN_DRIVE_HOLD_OUT  <= 1'b1;
            PERIPH_HALT_OUT     <= halt_d;
            DEVICE_RESET_OUT    <= dev_reset;
            SLEEP_SELECT_OUT    <= sleep_sel_d;
            REG_STBY_SEL_OUT    <= reg_stby_sel_d;
        end
    end

    // Checks on mode behaviour
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    sequence s_sleep_entry;
        mode_q == pwr_mode_pkg::ST_RUN && WAIT_IN && sleep_sel_q && !dev_reset;
    endsequence

    sequence s_sleep_hi_wake;
        SLEEP_OUT && irq_hi && IRQ_IN.sleep_ok && !dev_reset;
    endsequence

    a_sleep_entry: assert property (s_sleep_entry |=> SLEEP_OUT && !CLK_CTRL_OUT.cpu_clk_en)
        else $error("wait with sleep select did not sleep");

    a_sleep_clocks: assert property (SLEEP_OUT |-> !CLK_CTRL_OUT.cpu_clk_en &&
        !CLK_CTRL_OUT.periph_bus_clk_en && PERIPH_HALT_OUT == '1)
        else $error("clocks running in sleep");

    a_monitor_off: assert property (SLEEP_OUT |-> !CLK_FAIL_MON_EN_OUT && BROWNOUT_EN_OUT)
        else $error("monitor state wrong in sleep");

    a_keep_alive: assert property (SLEEP_OUT |-> KEEP_ALIVE_OUT == '1 && PIN_DRIVE_HOLD_OUT)
        else $error("sleep-capable unit stopped");

    a_high_wake: assert property (s_sleep_hi_wake ##1 !dev_reset |-> mode_q == pwr_mode_pkg::ST_WAKE
        ##1 !SLEEP_OUT)
        else $error("high priority irq did not wake");

    a_low_idle: assert property (SLEEP_OUT && irq_lo && IRQ_IN.sleep_ok && !irq_hi &&
        !WATCHDOG_TIMEOUT_IN && !dev_reset |=> IDLE_OUT && CLK_CTRL_OUT.periph_bus_clk_en && CLK_CTRL_OUT.cpu_halt)
        else $error("low priority irq did not idle");

    a_reset_exit: assert property (dev_reset |=> mode_q == pwr_mode_pkg::ST_RUN && DEVICE_RESET_OUT
        && !sleep_sel_q)
        else $error("reset did not end sleep");

    a_wake_delay: assert property ($rose(mode_q == pwr_mode_pkg::ST_WAKE) |->
        wake_cnt_q == pwr_mode_pkg::osc_delay($past(OSC_SRC_IN))
        + ($past(stby_q) ? pwr_mode_pkg::STBY_EXTRA_CYC : 12'h000))
        else $error("wake delay not loaded");

    a_stby_longer: assert property ($rose(mode_q == pwr_mode_pkg::ST_WAKE) && stby_q |->
        wake_cnt_q > pwr_mode_pkg::osc_delay($past(OSC_SRC_IN)))
        else $error("standby wake not longer");

    a_stby_entry: assert property (s_sleep_entry and reg_stby_sel_q |=> REG_STANDBY_OUT)
        else $error("regulator not in standby");

    a_idle_entry: assert property (mode_q == pwr_mode_pkg::ST_RUN && WAIT_IN && !sleep_sel_q && !dev_reset
        |=> IDLE_OUT && CLK_CTRL_OUT.cpu_halt && CLK_CTRL_OUT.periph_bus_clk_en)
        else $error("wait without sleep select did not idle");

    a_idle_halt: assert property (IDLE_OUT |-> PERIPH_HALT_OUT == $past(STOP_IN_IDLE_IN))
        else $error("stop-in-idle mask not applied");

    a_locked_write: assert property (OSC_CTRL_WR_IN && !unlocked && !dev_reset |=>
        $stable(sleep_sel_q))
        else $error("locked write changed sleep select");

endmodule

// File: sleep_standby_mode_control_tb_top.sv
`timescale 1ns/1ps

module sleep_standby_mode_control_tb_top;
    localparam logic [2:0]  CODES [5] = '{pwr_mode_pkg::OSC_FRC, pwr_mode_pkg::OSC_PLL, pwr_mode_pkg::OSC_PRI,
                                          pwr_mode_pkg::OSC_SOSC, pwr_mode_pkg::OSC_LOW_POWER_RC_OSC};
    localparam logic [11:0] DLY [5]   = '{pwr_mode_pkg::WAKE_FRC_CYC, pwr_mode_pkg::WAKE_PLL_CYC,
                                          pwr_mode_pkg::WAKE_PRI_CYC, pwr_mode_pkg::WAKE_SOSC_CYC,
                                          pwr_mode_pkg::WAKE_LOW_POWER_RC_OSC_CYC};

    logic                        clk = 1'b0;
    logic                        rst_n = 1'b0;
    logic                        wait_s;
    logic [2:0]                  cpu_pri;
    pwr_mode_pkg::irq_req_t      irq;
    logic                        wd_to = 1'b0;
    logic                        brownout = 1'b0;
    logic                        rst_req = 1'b0;
    logic [2:0]                  osc_src = 3'h0;
    logic                        key_wr = 1'b0;
    logic [31:0]                 key_data = 32'h0;
    logic                        osc_wr = 1'b0;
    logic                        pwr_wr = 1'b0;
    logic [31:0]                 ctl_data = 32'h0;
    logic [7:0]                  stop_mask = 8'hA5;
    pwr_mode_pkg::clk_ctrl_t     clk_ctrl;
    pwr_mode_pkg::keep_alive_t   keep;
    logic                        sleep_o, idle_o, reg_stby, mon_en, bo_en, pin_hold, dev_rst, sel_o, stby_sel;
    logic [7:0]                  halt;
    int                          n_mismatch = 0;
    int                          n_compared = 0;

    // 25 MHz system clock
    always #20 clk = ~clk;

    cpu_irq_model cpu_irq_model_i (.clk_in(clk), .wait_out(wait_s), .cpu_pri_out(cpu_pri), .irq_out(irq));

    sleep_standby_mode_control #(.NUM_PERIPH(8)) sleep_standby_mode_control_i (
        .REF_CLK_IN(clk), .RST_N_IN(rst_n), .WAIT_IN(wait_s), .CPU_PRI_IN(cpu_pri), .IRQ_IN(irq),
        .WATCHDOG_TIMEOUT_IN(wd_to), .BROWNOUT_IN(brownout), .RESET_REQ_IN(rst_req), .OSC_SRC_IN(osc_src),
        .UNLOCK_WR_IN(key_wr), .UNLOCK_DATA_IN(key_data), .OSC_CTRL_WR_IN(osc_wr), .OSC_CTRL_DATA_IN(ctl_data),
        .PWR_CTRL_WR_IN(pwr_wr), .PWR_CTRL_DATA_IN(ctl_data), .STOP_IN_IDLE_IN(stop_mask),
        .CLK_CTRL_OUT(clk_ctrl), .KEEP_ALIVE_OUT(keep), .SLEEP_OUT(sleep_o), .IDLE_OUT(idle_o),
        .REG_STANDBY_OUT(reg_stby), .CLK_FAIL_MON_EN_OUT(mon_en), .BROWNOUT_EN_OUT(bo_en),
        .PIN_DRIVE_HOLD_OUT(pin_hold), .PERIPH_HALT_OUT(halt), .DEVICE_RESET_OUT(dev_rst),
        .SLEEP_SELECT_OUT(sel_o), .REG_STBY_SEL_OUT(stby_sel));

    // Comparison helpers
    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_vec(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Control write strobes, one cycle each, entered at a falling edge
    task automatic wr_strobe(input int which, input logic [31:0] data);
        key_data = data;
        ctl_data = data;
        key_wr = (which == 0);
        osc_wr = (which == 1);
        pwr_wr = (which == 2);
        @(negedge clk);
        {key_wr, osc_wr, pwr_wr} = 3'h0;
        @(negedge clk);                      // Idle cycle keeps strobes apart
    endtask

    // Unlock then write the sleep select bit
    task automatic set_sel(input logic v);
        wr_strobe(0, pwr_mode_pkg::UNLOCK_KEY1);
        wr_strobe(0, pwr_mode_pkg::UNLOCK_KEY2);
        wr_strobe(1, {27'h0, v, 4'h0});
    endtask

    // Count cycles from the wake edge until the CPU clock is back
    task automatic wait_run(input string name, input logic [31:0] exp);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n == 1) begin
                wd_to = 1'b0;
                chk_bit("sleep_left", 1'b0, sleep_o);
                chk_bit("reg_stby_off", 1'b0, reg_stby);
            end
        end while (clk_ctrl.cpu_clk_en !== 1'b1 && n < 2000);
        chk_vec(name, exp, n);
        chk_vec("halt_run", 32'h0, {24'h0, halt});
        chk_bit("mon_back", 1'b1, mon_en);
    endtask

    // Sleep state of every output except idle, device reset and the two select bits
    task automatic chk_sleep(input logic stby);
        chk_bit("sleep", 1'b1, sleep_o);
        chk_vec("clk_ctrl", 32'h1, {29'h0, clk_ctrl});
        chk_vec("halt_sleep", 32'hFF, {24'h0, halt});
        chk_bit("mon_off", 1'b0, mon_en);
        chk_bit("brownout_on", 1'b1, bo_en);
        chk_vec("keep_alive", 32'h1F, {27'h0, keep});
        chk_bit("pin_hold", 1'b1, pin_hold);
        chk_bit("reg_stby", stby, reg_stby);
    endtask

    // Locked write refused, unlocked write accepted
    task automatic t_lock();
        wr_strobe(1, 32'h10);
        @(negedge clk);
        chk_bit("sel_locked", 1'b0, sel_o);
        set_sel(1'b1);
        chk_bit("sel_unlocked", 1'b1, sel_o);
    endtask

    // Sleep and wake for every oscillator source; first pass tries a non-sleep source
    task automatic t_sleep_wake();
        for (int i = 0; i < 5; i++) begin
            osc_src = CODES[i];
            cpu_irq_model_i.exec_wait(3'h3);
            chk_sleep(1'b0);
            if (i == 0) begin
                cpu_irq_model_i.set_irq(1'b0, 3'h7);
                repeat (3) @(negedge clk);
                chk_bit("no_sleep_src", 1'b1, sleep_o);
            end
            cpu_irq_model_i.set_irq(1'b1, 3'h4);
            wait_run("wake_cycles", {20'h0, DLY[i]} + 32'h1);
            cpu_irq_model_i.clr_irq();
        end
    endtask

    // Equal priority goes to Idle, higher priority exits; CPU priority raised to 5
    task automatic t_equal_pri();
        cpu_irq_model_i.exec_wait(3'h5);
        cpu_irq_model_i.set_irq(1'b1, 3'h5);
        @(negedge clk);
        chk_bit("idle_eq", 1'b1, idle_o);
        chk_vec("clk_idle", 32'h3, {29'h0, clk_ctrl} & 32'h3);
        chk_vec("halt_eq", 32'hA5, {24'h0, halt});
        cpu_irq_model_i.set_irq(1'b1, 3'h6);
        @(negedge clk);
        cpu_irq_model_i.clr_irq();
        chk_bit("idle_exit", 1'b0, idle_o);
        chk_bit("cpu_run", 1'b1, clk_ctrl.cpu_clk_en);
    endtask

    // Idle entry with select clear, a second stop mask, watchdog exit
    task automatic t_idle();
        set_sel(1'b0);
        stop_mask = 8'h3C;
        cpu_irq_model_i.exec_wait(3'h3);
        chk_bit("idle", 1'b1, idle_o);
        chk_bit("sleep_not", 1'b0, sleep_o);
        chk_vec("clk_idle", 32'h3, {29'h0, clk_ctrl} & 32'h3);
        chk_vec("halt_idle", 32'h3C, {24'h0, halt});
        wd_to = 1'b1;
        @(negedge clk);
        wd_to = 1'b0;
        chk_bit("idle_wd", 1'b0, idle_o);
    endtask

    // Standby Sleep, woken by watchdog, with regulator recovery
    task automatic t_standby();
        osc_src = pwr_mode_pkg::OSC_FRC;
        set_sel(1'b1);
        wr_strobe(2, 32'h1);
        chk_bit("stby_sel", 1'b1, stby_sel);
        cpu_irq_model_i.exec_wait(3'h3);
        chk_sleep(1'b1);
        wd_to = 1'b1;
        wait_run("stby_cycles", {20'h0, pwr_mode_pkg::WAKE_FRC_CYC + pwr_mode_pkg::STBY_EXTRA_CYC} + 32'h1);
    endtask

    // Device reset and brownout both end Sleep and clear the controls
    task automatic t_dev_reset();
        for (int k = 0; k < 2; k++) begin
            set_sel(1'b1);
            cpu_irq_model_i.exec_wait(3'h3);
            {brownout, rst_req} = (k == 0) ? 2'b01 : 2'b10;
            @(negedge clk);
            {brownout, rst_req} = 2'b00;
            chk_bit("dev_rst", 1'b1, dev_rst);
            chk_bit("rst_sleep", 1'b0, sleep_o);
            chk_bit("rst_cpu", 1'b1, clk_ctrl.cpu_clk_en);
            chk_bit("rst_sel", 1'b0, sel_o);
            chk_bit("rst_stby", 1'b0, stby_sel);
            @(negedge clk);
        end
    endtask

    task automatic print_verdict();
        $display("Mismatches %0d of %0d comparisons", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Hang guard, well past the expected run length
    initial begin
        #(5000 * 40);
        n_mismatch++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk_vec("rst_clk", 32'h6, {29'h0, clk_ctrl});
        chk_bit("rst_mon", 1'b1, mon_en);
        t_lock();
        t_sleep_wake();
        t_equal_pri();
        t_idle();
        t_standby();
        t_dev_reset();
        print_verdict();
    end
endmodule

// File: unlock_seq.sv
`timescale 1ns/1ps

// Two-key unlock guard for protected control writes
module unlock_seq (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        key_wr_in,
    input  wire logic [31:0] key_data_in,
    input  wire logic        clear_in,
    output logic             unlocked_out
);

    logic armed_q;
    logic armed_d;
    logic unlocked_q;
    logic unlocked_d;

    // Key 1 arms, key 2 right after unlocks, any other key relocks
    always_comb begin
        armed_d    = armed_q;
        unlocked_d = unlocked_q;
        if (clear_in) begin
            armed_d    = 1'b0;
            unlocked_d = 1'b0;
        end else if (key_wr_in) begin
            armed_d    = (key_data_in == pwr_mode_pkg::UNLOCK_KEY1);
            unlocked_d = armed_q && (key_data_in == pwr_mode_pkg::UNLOCK_KEY2);
        end
    end

    // Register stage
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            armed_q    <= 1'b0;
            unlocked_q <= 1'b0;
        end else begin
            armed_q    <= armed_d;
            unlocked_q <= unlocked_d;
        end
    end

    assign unlocked_out = unlocked_q;

    // Unlock only follows key 2 after key 1
    a_unlock_order: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(unlocked_q) |-> $past(key_wr_in && armed_q && key_data_in == pwr_mode_pkg::UNLOCK_KEY2))
        else $error("unlock without key pair");

endmodule
